// ==== common/vei_defines.svh ====
`ifndef VEI_DEFINES_SVH
`define VEI_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VEI_OFF_IN_FMT     7'h02
`define VEI_OFF_VPROC      7'h03
`define VEI_OFF_TIO1       7'h04
`define VEI_OFF_TIO2       7'h05

// ****************************************************************
// Reset values and writable bit masks
// ****************************************************************
`define VEI_RST_IN_FMT     8'h00
`define VEI_RST_VPROC      8'hA0
`define VEI_RST_TIO1       8'h00
`define VEI_RST_TIO2       8'h00
`define VEI_MSK_IN_FMT     8'hE0
`define VEI_MSK_VPROC      8'hE0
`define VEI_MSK_TIO1       8'hBF
`define VEI_MSK_TIO2       8'h3B
`define VEI_RD_UNMAPPED    8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define VEI_FMT_MSB        7
`define VEI_FMT_LSB        5
`define VEI_VP_LPF         7
`define VEI_VP_LIMIT       6
`define VEI_VP_SCH         5
`define VEI_T1_BTIM        7
`define VEI_T1_BDIR        5
`define VEI_T1_BPOL        4
`define VEI_T1_SDIR        3
`define VEI_T1_HPOL        2
`define VEI_T1_VPOL        1
`define VEI_T1_FPOL        0
`define VEI_T2_CPOL        5
`define VEI_T2_CDIR        4
`define VEI_T2_ASPECT      3
`define VEI_T2_SRC_MSB     1
`define VEI_T2_SRC_LSB     0

// ****************************************************************
// Codes
// ****************************************************************
`define VEI_CODE_YC16      3'h0
`define VEI_CODE_YC8       3'h1
`define VEI_CODE_B656      3'h2
`define VEI_SRC_FIXED      2'h0
`define VEI_SRC_RTC        2'h2
`define VEI_SRC_HOST       2'h3
`define VEI_I2C_ADDR_HI    6'h10
`define VEI_FIELDS_NTSC    3'h3
`define VEI_FIELDS_PAL     3'h7
`define VEI_STEP_FIXED     32'h2000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define VEI_CLK_PERIOD_NS  10
`define VEI_PIX_PERIOD_NS  40
`define VEI_PIX_HALF_CYC   ((`VEI_PIX_PERIOD_NS / 2) / `VEI_CLK_PERIOD_NS)

`endif

// ==== common/vei_pkg.sv ====
package vei_pkg;

  typedef enum logic [1:0] {
    FMT_YC16,
    FMT_YC8,
    FMT_B656,
    FMT_RSVD
  } vei_fmt_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } vei_state_type;

  typedef struct packed {
    logic blank;
    logic hsync;
    logic vsync;
    logic field_odd;
  } vei_timing_type;

  typedef struct packed {
    logic [7:0] in_fmt;
    logic [7:0] vproc;
    logic [7:0] tio1;
    logic [7:0] tio2;
  } vei_cfg_type;

  typedef struct packed {
    vei_fmt_type fmt;
    logic        luma_lpf;
    logic        comp_limit;
    logic        sch_reset_en;
    logic        square_pixel;
    logic [1:0]  step_src;
  } vei_mode_type;

endpackage

// ==== rtl/vei_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module vei_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/vei_timing_cfg.sv ====
// Notes on behaviour
// - Format bits 7-5 pick 16-bit YCbCr, 8-bit YCbCr or BT.656; others reserved.
// - Video processing bit 7 turns the luminance lowpass filter on.
// - Video processing bit 6 clamps composite active video near half sync height.
// - Bit 5 realigns subcarrier phase every 4 NTSC or 8 PAL fields; else never.
// - Timing bit 5 makes the blanking strobe an output; zero means input.
// - Timing bit 4 sets blanking polarity, high during blanking when one.
// - Timing bit 3 makes line and frame sync outputs, device is timing master.
// - Timing bit 2 sets line sync polarity, high during sync when one.
// - Timing bit 1 sets frame sync polarity, high during sync when one.
// - Timing bit 0 sets field polarity, high during odd fields when one.
// - Second timing bit 5 captures inputs in the high clock phase, else low.
// - Second timing bit 4 makes the pixel clock pin a driven output.
// - Second timing bit 3 selects square pixels, zero selects BT.601 rectangular.
// - Step source: 00 fixed, 10 ancillary real-time data, 11 host step; 01 reserved.
// - Reserved bits read as zero and writes to them are dropped.
// - Seven-bit pointer loads from first written byte, advances after each data byte.
`include "vei_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module vei_timing_cfg
  import vei_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Two-wire host port and address strap
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  input  wire logic            sa_i,
  // Pixel clock pin
  input  wire logic            pix_clk_i,
  output logic                 pix_clk_o,
  output logic                 pix_clk_oe,
  // Pixel data pins
  input  wire logic [15:0]     pixel_i,
  // Timing pins
  input  wire logic            blank_i,
  output logic                 blank_o,
  output logic                 blank_oe,
  input  wire logic            hsync_i,
  output logic                 hsync_o,
  output logic                 hsync_oe,
  input  wire logic            vsync_i,
  output logic                 vsync_o,
  output logic                 vsync_oe,
  input  wire logic            field_i,
  output logic                 field_o,
  output logic                 field_oe,
  // Internal timing generator and step sources
  input  wire vei_timing_type  mst_tim,
  input  wire logic            pal_mode,
  input  wire logic [31:0]     rtc_step,
  input  wire logic [31:0]     host_step,
  // Datapath controls
  output vei_mode_type         mode,
  output vei_timing_type       tim,
  output logic [15:0]          pix_data,
  output logic                 pix_valid,
  output logic                 sch_realign,
  output logic [31:0]          phase_step
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [23:0] raw_w;
  logic [23:0] syn_w;

  assign raw_w = {pixel_i, field_i, vsync_i, hsync_i, blank_i, pix_clk_i, sa_i, sda_i, scl_i};

  vei_sync2 #(.WIDTH(24)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (raw_w),
    .q     (syn_w)
  );

  wire        scl_s   = syn_w[0];
  wire        sda_s   = syn_w[1];
  wire        sa_s    = syn_w[2];
  wire        pix_s   = syn_w[3];
  wire        blank_s = syn_w[4];
  wire        hsync_s = syn_w[5];
  wire        vsync_s = syn_w[6];
  wire        field_s = syn_w[7];
  wire [15:0] pixel_s = syn_w[23:8];

  // ****************************************************************
  // Two-wire slave
  // ****************************************************************
  vei_state_type state_q;
  logic          scl_p_q;
  logic          sda_p_q;
  logic [3:0]    cnt_q;
  logic [7:0]    shift_q;
  logic [7:0]    tx_q;
  logic [6:0]    ptr_q;
  logic          rw_q;
  logic          first_q;
  logic          nack_q;
  logic          drive_q;
  logic [7:0]    rd_byte;
  vei_cfg_type   cfg_q;
  vei_cfg_type   eff_q;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_w  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_w   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire addr_hit = (shift_q[7:1] == {`VEI_I2C_ADDR_HI, sa_s});
  wire wr_stb   = scl_fall & (state_q == ST_WRITE) & (cnt_q == 4'h8) & ~first_q;

  // Bytes past the four local registers read as zero.
  assign rd_byte = (ptr_q == `VEI_OFF_IN_FMT) ? cfg_q.in_fmt :
                   (ptr_q == `VEI_OFF_VPROC)  ? cfg_q.vproc  :
                   (ptr_q == `VEI_OFF_TIO1)   ? cfg_q.tio1   :
                   (ptr_q == `VEI_OFF_TIO2)   ? cfg_q.tio2   : `VEI_RD_UNMAPPED;

  assign sda_o  = 1'b0;
  assign sda_oe = drive_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Start and stop are honoured in every state so a lost host can always recover.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 7'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      drive_q <= 1'b0;
    end else if (start_w) begin
      state_q <= ST_ADDR;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_w) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else if (scl_rise) begin
      if (state_q == ST_ADDR || state_q == ST_WRITE) begin
        shift_q <= {shift_q[6:0], sda_s};
        cnt_q   <= cnt_q + 4'h1;
      end
      if (state_q == ST_READ_ACK) begin
        nack_q <= sda_s;
      end
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (addr_hit) begin
              state_q <= ST_ADDR_ACK;
              drive_q <= 1'b1;
              rw_q    <= shift_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_q   <= 4'h0;
          first_q <= ~rw_q;
          if (rw_q) begin
            state_q <= ST_READ;
            tx_q    <= {rd_byte[6:0], 1'b0};
            drive_q <= ~rd_byte[7];
          end else begin
            state_q <= ST_WRITE;
            drive_q <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (cnt_q == 4'h8) begin
            state_q <= ST_WRITE_ACK;
            drive_q <= 1'b1;
            first_q <= 1'b0;
            if (first_q) begin
              ptr_q <= shift_q[6:0];
            end else begin
              ptr_q <= ptr_q + 7'h01;
            end
          end
        end
        ST_WRITE_ACK: begin
          state_q <= ST_WRITE;
          drive_q <= 1'b0;
          cnt_q   <= 4'h0;
        end
        ST_READ: begin
          if (cnt_q == 4'h7) begin
            state_q <= ST_READ_ACK;
            drive_q <= 1'b0;
            ptr_q   <= ptr_q + 7'h01;
          end else begin
            drive_q <= ~tx_q[7];
            tx_q    <= {tx_q[6:0], 1'b0};
            cnt_q   <= cnt_q + 4'h1;
          end
        end
        ST_READ_ACK: begin
          if (nack_q) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_READ;
            cnt_q   <= 4'h0;
            tx_q    <= {rd_byte[6:0], 1'b0};
            drive_q <= ~rd_byte[7];
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  wire hit_in = wr_stb & (ptr_q == `VEI_OFF_IN_FMT);
  wire hit_vp = wr_stb & (ptr_q == `VEI_OFF_VPROC);
  wire hit_t1 = wr_stb & (ptr_q == `VEI_OFF_TIO1);
  wire hit_t2 = wr_stb & (ptr_q == `VEI_OFF_TIO2);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= {`VEI_RST_IN_FMT, `VEI_RST_VPROC, `VEI_RST_TIO1, `VEI_RST_TIO2};
    end else begin
      if (hit_in) cfg_q.in_fmt <= shift_q & `VEI_MSK_IN_FMT;
      if (hit_vp) cfg_q.vproc  <= shift_q & `VEI_MSK_VPROC;
      if (hit_t1) cfg_q.tio1   <= shift_q & `VEI_MSK_TIO1;
      if (hit_t2) cfg_q.tio2   <= shift_q & `VEI_MSK_TIO2;
    end
  end

  // ****************************************************************
  // Pixel clock and capture edge
  // ****************************************************************
  // Direction and phase act straight from the register, so the block
  // cannot lock itself out of a stopped external clock.
  logic [3:0] div_q;
  logic       pclk_q;
  logic       ref_p_q;

  wire ref_w = cfg_q.tio2[`VEI_T2_CDIR] ? pclk_q : pix_s;
  wire cap_w = cfg_q.tio2[`VEI_T2_CPOL] ? (ref_w & ~ref_p_q) : (~ref_w & ref_p_q);

  assign pix_clk_o  = pclk_q;
  assign pix_clk_oe = cfg_q.tio2[`VEI_T2_CDIR];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q   <= 4'h0;
      pclk_q  <= 1'b0;
      ref_p_q <= 1'b0;
    end else begin
      ref_p_q <= ref_w;
      if (div_q == 4'(`VEI_PIX_HALF_CYC - 1)) begin
        div_q  <= 4'h0;
        pclk_q <= ~pclk_q;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // Working copy of the configuration, moved on each capture edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eff_q <= {`VEI_RST_IN_FMT, `VEI_RST_VPROC, `VEI_RST_TIO1, `VEI_RST_TIO2};
    end else if (cap_w) begin
      eff_q <= cfg_q;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire [2:0] fmt_code = eff_q.in_fmt[`VEI_FMT_MSB:`VEI_FMT_LSB];
  wire [1:0] src_w    = eff_q.tio2[`VEI_T2_SRC_MSB:`VEI_T2_SRC_LSB];

  assign mode.fmt = (fmt_code == `VEI_CODE_YC16) ? FMT_YC16 :
                    (fmt_code == `VEI_CODE_YC8)  ? FMT_YC8  :
                    (fmt_code == `VEI_CODE_B656) ? FMT_B656 : FMT_RSVD;
  assign mode.luma_lpf     = eff_q.vproc[`VEI_VP_LPF];
  assign mode.comp_limit   = eff_q.vproc[`VEI_VP_LIMIT];
  assign mode.sch_reset_en = eff_q.vproc[`VEI_VP_SCH];
  // Square pixels with BT.656 input are left to the host to avoid.
  assign mode.square_pixel = eff_q.tio2[`VEI_T2_ASPECT];
  assign mode.step_src     = src_w;

  // ****************************************************************
  // Timing pins
  // ****************************************************************
  wire bdir = eff_q.tio1[`VEI_T1_BDIR];
  wire btim = eff_q.tio1[`VEI_T1_BTIM];
  wire sdir = eff_q.tio1[`VEI_T1_SDIR];
  wire bpol = eff_q.tio1[`VEI_T1_BPOL];
  wire hpol = eff_q.tio1[`VEI_T1_HPOL];
  wire vpol = eff_q.tio1[`VEI_T1_VPOL];
  wire fpol = eff_q.tio1[`VEI_T1_FPOL];

  vei_timing_type tim_w;

  assign tim_w.blank     = bdir ? mst_tim.blank : (blank_s ~^ bpol);
  assign tim_w.hsync     = sdir ? mst_tim.hsync : (hsync_s ~^ hpol);
  assign tim_w.vsync     = sdir ? mst_tim.vsync : (vsync_s ~^ vpol);
  assign tim_w.field_odd = sdir ? mst_tim.field_odd : (field_s ~^ fpol);

  assign blank_oe = bdir;
  assign hsync_oe = sdir;
  assign vsync_oe = sdir;
  assign field_oe = sdir;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blank_o <= 1'b0;
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      field_o <= 1'b0;
    end else begin
      blank_o <= mst_tim.blank ~^ bpol;
      hsync_o <= mst_tim.hsync ~^ hpol;
      vsync_o <= mst_tim.vsync ~^ vpol;
      field_o <= mst_tim.field_odd ~^ fpol;
    end
  end

  // ****************************************************************
  // Pixel capture, field count and phase step
  // ****************************************************************
  logic [2:0]  fcnt_q;
  logic [31:0] step_w;

  wire take_w  = cap_w & ~tim_w.blank & ((bdir & ~btim) ? ~tim.blank : 1'b1);
  wire fld_evt = cap_w & (tim_w.field_odd != tim.field_odd);
  wire [2:0] f_lim = pal_mode ? `VEI_FIELDS_PAL : `VEI_FIELDS_NTSC;
  wire f_wrap  = (fcnt_q == f_lim);

  // The reserved source code keeps the last step rather than glitching.
  assign step_w = (src_w == `VEI_SRC_FIXED) ? `VEI_STEP_FIXED :
                  (src_w == `VEI_SRC_RTC)   ? rtc_step       :
                  (src_w == `VEI_SRC_HOST)  ? host_step      : phase_step;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tim         <= '0;
      pix_data    <= 16'h0000;
      pix_valid   <= 1'b0;
      fcnt_q      <= 3'h0;
      sch_realign <= 1'b0;
      phase_step  <= `VEI_STEP_FIXED;
    end else begin
      if (cap_w) tim <= tim_w;
      if (take_w) pix_data <= pixel_s;
      pix_valid   <= take_w;
      if (fld_evt) fcnt_q <= f_wrap ? 3'h0 : fcnt_q + 3'h1;
      sch_realign <= fld_evt & f_wrap & eff_q.vproc[`VEI_VP_SCH];
      phase_step  <= step_w;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_reserved_zero: assert property ((ptr_q == `VEI_OFF_VPROC) |-> (rd_byte[4:0] == 5'h00))
    else $error("Reserved bits of the processing register read nonzero.");
  chk_shadow_follow: assert property (cap_w |=> (eff_q == $past(cfg_q)))
    else $error("Working configuration missed a capture edge.");
  chk_ptr_advance: assert property (wr_stb |=> (ptr_q == $past(ptr_q) + 7'h01))
    else $error("Pointer did not advance after a data byte.");
  chk_hsync_level: assert property (sdir |=>
    (hsync_o == ($past(mst_tim.hsync) ~^ $past(hpol))))
    else $error("Line sync pin level wrong for its polarity.");
  chk_vsync_level: assert property (sdir |=>
    (vsync_o == ($past(mst_tim.vsync) ~^ $past(vpol))))
    else $error("Frame sync pin level wrong for its polarity.");
  chk_field_level: assert property (field_oe |=>
    (field_o == ($past(mst_tim.field_odd) ~^ $past(fpol))))
    else $error("Field pin level wrong for its polarity.");
  chk_realign_off: assert property (!eff_q.vproc[`VEI_VP_SCH] |=> !sch_realign)
    else $error("Phase realigned while realignment is off.");
  chk_step_host: assert property ((src_w == `VEI_SRC_HOST) |=> (phase_step == $past(host_step)))
    else $error("Phase step not taken from the host value.");
  chk_take_delay: assert property ((cap_w && bdir && !btim && tim.blank && !tim_w.blank)
    |=> !pix_valid)
    else $error("Pixel taken on the negation edge in delayed mode.");

endmodule

`default_nettype wire

// ==== dv/vei_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module vei_src_model (
  // Source settings
  input  wire logic        cap_hi,
  input  wire logic [3:0]  pol,
  input  wire logic        btim,
  input  wire logic        blank_w,
  // Source pins
  output logic             pclk,
  output logic [15:0]      pixel,
  output logic             blank,
  output logic             hsync,
  output logic             vsync,
  output logic             field
);
  // ****************
  // Line generator
  // ****************
  logic [3:0] cnt   = 4'h0;
  logic [2:0] line  = 3'h0;
  logic       act_q = 1'b0;
  logic       act;

  // A video source runs its pixel clock freely, also between lines.
  initial begin
    pclk  = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Data moves on the edge opposite the capture edge, so it is stable when taken.
  assign act = blank_w ^ pol[3];
  always @(pclk) begin
    if (pclk != cap_hi) begin
      cnt   <= cnt + 4'h1;
      line  <= (cnt == 4'hF) ? line + 3'h1 : line;
      act_q <= act;
      pixel <= {8'hA5, 3'h0, btim ? act : act_q, cnt + 4'h1};
    end
  end
  assign blank = ~((cnt < 4'h4) ^ pol[3]);
  assign hsync = ~((cnt < 4'h2) ^ pol[2]);
  assign vsync = ~((line == 3'h0) ^ pol[1]);
  assign field = ~(line[0] ^ pol[0]);
endmodule

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import vei_pkg::*;
;
  // ****************
  // Signals
  // ****************
  typedef struct packed {
    logic [6:0] off;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] md;
    logic [4:0] oe;
  } vei_row_type;

  logic           clk, rst_n, scl_i, sda_h, cap_hi, pal_mode, p_clk;
  logic           sda_o, sda_oe, pix_clk_o, pix_clk_oe, pix_valid, sch_realign;
  logic           blank_o, blank_oe, hsync_o, hsync_oe, vsync_o, vsync_oe;
  logic           field_o, field_oe, p_blank, p_hsync, p_vsync, p_field;
  logic [3:0]     pol;
  logic [15:0]    pixel_i, pix_data;
  logic [31:0]    rtc_step, host_step, phase_step;
  vei_timing_type mst_tim, tim;
  vei_mode_type   mode;
  vei_row_type    rows [13];
  int             n_errors, n_tests;

  // Open-drain data line: a released line is pulled high.
  wire        sda_i     = sda_h & ~(sda_oe & ~sda_o);
  wire        sa_i      = 1'b0;
  wire        pix_clk_i = pix_clk_oe ? pix_clk_o : p_clk;
  wire        blank_i   = blank_oe ? blank_o : p_blank;
  wire        hsync_i   = hsync_oe ? hsync_o : p_hsync;
  wire        vsync_i   = vsync_oe ? vsync_o : p_vsync;
  wire        field_i   = field_oe ? field_o : p_field;
  wire [16:0] cur       = {mode, pix_clk_oe, blank_oe, hsync_oe, vsync_oe, field_oe,
                           blank_o, hsync_o, vsync_o, field_o};

  vei_timing_cfg u_dut (
    .clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .sa_i, .pix_clk_i, .pix_clk_o,
    .pix_clk_oe, .pixel_i, .blank_i, .blank_o, .blank_oe, .hsync_i, .hsync_o,
    .hsync_oe, .vsync_i, .vsync_o, .vsync_oe, .field_i, .field_o, .field_oe,
    .mst_tim, .pal_mode, .rtc_step, .host_step, .mode, .tim, .pix_data,
    .pix_valid, .sch_realign, .phase_step
  );
  vei_src_model u_src (
    .cap_hi, .pol, .btim(1'b0), .blank_w(blank_i), .pclk(p_clk), .pixel(pixel_i),
    .blank(p_blank), .hsync(p_hsync), .vsync(p_vsync), .field(p_field)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************
  // Tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Each line phase lasts six clocks, above the four that the port needs.
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk) sda_h <= b;
    tick(5);
    @(posedge clk) scl_i <= 1'b1;
    tick(5);
    #1 r = sda_i;
    @(posedge clk) scl_i <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] r,
                         output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(nine, b);
    ack = ~b;
  endtask
  task automatic start_c;
    @(posedge clk) sda_h <= 1'b1;
    tick(5);
    @(posedge clk) scl_i <= 1'b1;
    tick(5);
    @(posedge clk) sda_h <= 1'b0;
    tick(5);
    @(posedge clk) scl_i <= 1'b0;
  endtask
  task automatic stop_c;
    @(posedge clk) sda_h <= 1'b0;
    tick(5);
    @(posedge clk) scl_i <= 1'b1;
    tick(5);
    @(posedge clk) sda_h <= 1'b1;
    tick(5);
  endtask
  task automatic wr(input logic [6:0] off, input int n, input logic [31:0] d);
    logic [7:0] r;
    logic       a;
    start_c();
    byte_io(8'h40, 1'b1, r, a);
    chk(a, 1'b1);
    byte_io({1'b0, off}, 1'b1, r, a);
    for (int i = 0; i < n; i++) byte_io(d[8*i +: 8], 1'b1, r, a);
    stop_c();
  endtask
  task automatic rd(input logic [6:0] off, input int n, output logic [31:0] q);
    logic [7:0] r;
    logic       a;
    q = 32'h0000_0000;
    start_c();
    byte_io(8'h40, 1'b1, r, a);
    byte_io({1'b0, off}, 1'b1, r, a);
    start_c();
    byte_io(8'h41, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, i == n - 1, r, a);
      q[8*i +: 8] = r;
    end
    stop_c();
  endtask
  task automatic settle(input logic [16:0] w);
    int k;
    for (k = 0; k < 80 && cur !== w; k++) @(negedge clk);
    if (k == 80) begin
      chk(cur, w);
      end_sim();
    end
  endtask
  task automatic gap(output int g);
    int k;
    @(negedge clk);
    for (k = 0; k < 1100 && sch_realign !== 1'b1; k++) @(negedge clk);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (g < 1100 && sch_realign !== 1'b1);
    if (g == 1100 || k == 1100) begin
      chk(k == 1100 || g == 1100, 1'b0);
      end_sim();
    end
  endtask
  task automatic do_reset;
    @(posedge clk) rst_n <= 1'b0;
    tick(4);
    @(posedge clk) rst_n <= 1'b1;
    tick(3);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    vei_row_type r;
    logic [31:0] q, step;
    logic [16:0] want;
    logic [7:0]  t1, rb;
    logic        a, pc;
    int          g, n, nv;
    {rst_n, scl_i, sda_h, cap_hi, pal_mode, pol} = {5'b01100, 4'h0};
    {mst_tim, rtc_step, host_step} = {4'b1010, 32'h1234_5678, 32'h0BAD_F00D};
    rows = '{'{7'h02,8'hFF,8'hE0,8'hE8,5'h00}, '{7'h02,8'h20,8'h20,8'h68,5'h00},
             '{7'h02,8'h40,8'h40,8'hA8,5'h00}, '{7'h02,8'h1F,8'h00,8'h28,5'h00},
             '{7'h03,8'h5F,8'h40,8'h10,5'h00}, '{7'h03,8'hFF,8'hE0,8'h38,5'h00},
             '{7'h05,8'hFF,8'h3B,8'h3F,5'h10}, '{7'h05,8'h02,8'h02,8'h3A,5'h00},
             '{7'h05,8'h01,8'h01,8'h39,5'h00}, '{7'h05,8'h00,8'h00,8'h38,5'h00},
             '{7'h06,8'hFF,8'h00,8'h38,5'h00}, '{7'h04,8'hFF,8'hBF,8'h38,5'h0F},
             '{7'h04,8'h14,8'h14,8'h38,5'h00}};
    {t1, step} = {8'h00, 32'h2000_0000};
    do_reset();
    foreach (rows[i]) begin
      r = rows[i];
      wr(r.off, 1, 32'(r.wd));
      rd(r.off, 1, q);
      chk(q, 32'(r.rd));
      if (r.off == 7'h04) t1 = r.rd;
      if (r.md[1:0] != 2'h1) step = r.md[1] ? (r.md[0] ? host_step : rtc_step) : 32'h2000_0000;
      want = {r.md, r.oe, ~(4'b1010 ^ {t1[4], t1[2:0]})};
      settle(want);
      chk(cur[16:9], want[16:9]);
      chk(cur[8:0], want[8:0]);
      tick(2);
      chk(phase_step, step);
    end
    for (int k = 0; k < 4; k++) begin
      wr(7'h04, 1, {27'h0, k[0], 4'h0});
      wr(7'h05, 1, {26'h0, k[1], 5'h0});
      @(posedge clk) pol <= {k[0], 3'b000};
      cap_hi <= k[1];
      tick(20);
      nv = 0;
      repeat (80) begin
        @(negedge clk);
        if (pix_valid === 1'b1) begin
          nv++;
          chk({pix_data[15:8], tim.blank, pix_data[3:2] != 2'b00}, {8'hA5, 2'b01});
        end
      end
      chk(nv > 9, 1'b1);
    end
    wr(7'h04, 1, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) pal_mode <= m[0];
      gap(g);
      gap(g);
      chk(g, m[0] ? 512 : 256);
    end
    wr(7'h03, 1, 32'h0000_0080);
    n = 0;
    repeat (700) begin
      @(negedge clk);
      if (sch_realign === 1'b1) n++;
    end
    chk(n, 0);
    // Blank driven by the block: the first open capture edge waits unless bit 7 is set.
    wr(7'h05, 1, 32'h0000_0010);
    for (int b = 0; b < 2; b++) begin
      wr(7'h04, 1, {24'h0, b[0], 7'h20});
      tick(20);
      pc = 1'b0;
      for (n = 0; n < 9 && !(pc && !pix_clk_o); n++) begin
        pc = pix_clk_o;
        @(negedge clk);
      end
      @(posedge clk) mst_tim.blank <= 1'b0;
      for (n = 0; n < 20 && pix_valid !== 1'b1; n++) @(negedge clk);
      chk(n, b ? 5 : 9);
      @(posedge clk) mst_tim.blank <= 1'b1;
    end
    wr(7'h02, 4, 32'hFFFF_FFFF);
    rd(7'h02, 4, q);
    chk(q, 32'h3BBF_E0E0);
    start_c();
    byte_io(8'h42, 1'b1, rb, a);
    chk(a, 1'b0);
    stop_c();
    do_reset();
    chk(cur, 32'h0000_5005);
    chk(phase_step, 32'h2000_0000);
    rd(7'h02, 4, q);
    chk(q, 32'h0000_A000);
    end_sim();
  end
endmodule

`default_nettype wire
